// *** pgms_params.svh ***
// Constants for the output pin select and status register bank
`ifndef PGMS_PARAMS_SVH
`define PGMS_PARAMS_SVH

// Register indices as seen in the serial frame
`define PGMS_ADDR_PIN_CFG   7'h0F
`define PGMS_ADDR_TUNE      7'h10
`define PGMS_ADDR_APPROX    7'h11
`define PGMS_ADDR_LOCK      7'h12
`define PGMS_ADDR_SELFTEST  7'h13

// Reset values
`define PGMS_RST_PIN_CFG    10'h001
`define PGMS_RST_TUNE       8'h20
`define PGMS_RST_APPROX     20'h7FFFF
`define PGMS_RST_SELFTEST   17'h01259

// Field positions of the pin config register
`define PGMS_SEL_MSB        4
`define PGMS_TEST_BIT       5
`define PGMS_NOMUX_BIT      6
`define PGMS_ALWAYS_ON_BIT  7
`define PGMS_NO_HIGH_BIT    8
`define PGMS_NO_LOW_BIT     9

// Field positions of the status registers
`define PGMS_BUSY_BIT       8
`define PGMS_SIGN_BIT       19
`define PGMS_LOCK_BIT       1

// Serial frame: 1 direction bit, 7 address bits, 24 data bits
`define PGMS_ADDR_W         7
`define PGMS_DATA_W         24
`define PGMS_HDR_BITS       6'd8
`define PGMS_FRAME_BITS     6'd32

`endif

// *** pgms_pkg.sv ***
// Types shared by the output pin select and status register bank
`default_nettype none
package pgms_pkg;
   // Phase of the serial frame
   typedef enum logic [1:0] {
      PGMS_IDLE,
      PGMS_HEADER,
      PGMS_DATA,
      PGMS_DONE
   } pgms_phase_t;
endpackage
`default_nettype wire

// *** pgms_sync.sv ***
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module pgms_sync #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   // Asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;   // First stage, read only by the second

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         // Two stages per bit; only the second stage looks at the first
         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               meta_reg[g] <= 1'b0;
               sync_o[g]   <= 1'b0;
            end else begin
               meta_reg[g] <= async_i[g];
               sync_o[g]   <= meta_reg[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** pgms_route.sv ***
// Selector that routes one internal signal toward the shared pin
`default_nettype none
module pgms_route (
   // Select and test data
   input  wire logic [4:0]  sel_i,
   input  wire logic        test_bit_i,
   // Internal sources, index equals select code
   input  wire logic [31:0] src_i,
   // Routed level and pull requests
   output logic             route_o,
   output logic             pull_up_o,
   output logic             pull_down_o
);
   // Codes that route a logic level rather than a pull or nothing
   function automatic logic is_level(input logic [4:0] code);
      is_level = !(code inside {5'h05, 5'h06, 5'h07, 5'h1A, 5'h1B, 5'h1C, 5'h1D});
   endfunction

   // Code 0 takes the test bit; unused and pull codes give low
   always_comb begin
      if (sel_i == 5'h00) begin
         route_o = test_bit_i;
      end else if (is_level(sel_i)) begin
         route_o = src_i[sel_i];
      end else begin
         route_o = 1'b0;
      end
   end

   // Pull resistors from the slip_prevention node
   always_comb begin
      pull_up_o   = (sel_i == 5'h05);
      pull_down_o = (sel_i == 5'h06);
   end
endmodule
`default_nettype wire

// *** pgms_regs.sv ***
// Pin select and status register bank behind the serial port
`include "pgms_params.svh"
`default_nettype none
module pgms_regs (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Serial port pins, asynchronous to clk_sys_i
   input  wire logic        spi_sclk_i,
   input  wire logic        spi_sen_i,
   input  wire logic        spi_sdi_i,
   // Lock or serial out pin, driven as data and enable
   output logic             pin_o,
   output logic             pin_oe_o,
   output logic             high_side_drive_en_o,
   output logic             low_side_drive_en_o,
   // Pull resistors on the slip_prevention node
   output logic             slip_pull_up_o,
   output logic             slip_pull_down_o,
   // Pin enable from register 0x08 bit 5, same clock
   input  wire logic        pin_enable_i,
   // Internal signals to route, index is select code
   input  wire logic [31:0] route_src_i,
   // Calibration results, same clock
   input  wire logic        cal_busy_i,
   input  wire logic        cal_done_i,
   input  wire logic [7:0]  cal_switch_i,
   // Approximation error, same clock
   input  wire logic        approx_valid_i,
   input  wire logic [18:0] approx_mag_i,
   input  wire logic        approx_sign_i,
   // Lock detect, same clock
   input  wire logic        lock_i,
   // Config fields for the rest of the device
   output logic [4:0]       output_signal_select_o,
   output logic             general_output_o
);
   import pgms_pkg::*;
   // The serial pins share no clock with clk_sys_i; every pin change is
   // seen three cycles late, so each serial clock phase must last at
   // least four system clocks for an edge to be caught

   // Synchronised pins
   logic        sclk_s;                   // Serial clock after two flops
   logic        sen_s;                    // Enable after two flops
   logic        sdi_s;                    // Data after two flops
   logic        sclk_d_reg;               // Previous serial clock level
   logic        rise;                     // Serial clock rising edge
   logic        fall;                     // Serial clock falling edge

   // Frame state
   pgms_phase_t phase_reg;                // Frame phase
   logic [5:0]  cnt_reg;                  // Bits received in frame
   logic [31:0] shin_reg;                 // Input shift register
   logic [23:0] shout_reg;                // Output shift register
   logic        rd_reg;                   // Frame is a read
   logic        read_active;              // Read data phase running

   // Registers
   // Only bits 9:0 of the pin config exist; the rest read zero
   logic [9:0]  pin_cfg_reg;              // Pin config fields
   logic [7:0]  tune_reg;                 // Calibrated switch setting
   logic [19:0] approx_reg;               // Sign and magnitude
   logic [23:0] rdata;                    // Read data of addressed reg

   // Routed signal
   logic        routed;                   // Selector output
   logic        pull_up;                  // Pull-up request
   logic        pull_down;                // Pull-down request
   logic        general_level;            // Level meant for the pin

   // Pins pass two flops before any use
   // Clock, enable and data take the same two stages, so their
   // timing relative to each other is kept
   pgms_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .async_i   ({spi_sclk_i, spi_sen_i, spi_sdi_i}),
      .sync_o    ({sclk_s, sen_s, sdi_s})
   );

   // Edge detect on the synchronised clock only
   // Reset level matches the idle low clock, so no false edge follows reset
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sclk_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
      end
   end

   // Falling edge moves read data; rising edge samples input data
   assign rise = sclk_s & ~sclk_d_reg;
   assign fall = ~sclk_s & sclk_d_reg;

   // Frame phase tracking; a frame ends when enable drops
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         phase_reg <= PGMS_IDLE;
      end else if (!sen_s) begin
         // Enable low aborts any frame; a cut write never commits
         phase_reg <= PGMS_IDLE;
      end else begin
         unique case (phase_reg)
            PGMS_IDLE: begin
               // Leave idle one cycle after enable is seen high
               phase_reg <= PGMS_HEADER;
            end
            PGMS_HEADER: begin
               // Header done after direction and address
               if (rise && cnt_reg == `PGMS_HDR_BITS - 6'd1) begin
                  phase_reg <= PGMS_DATA;
               end
            end
            PGMS_DATA: begin
               if (rise && cnt_reg == `PGMS_FRAME_BITS - 6'd1) begin
                  phase_reg <= PGMS_DONE;
               end
            end
            PGMS_DONE: begin
               // Extra clocks are ignored until enable drops
               phase_reg <= PGMS_DONE;
            end
         endcase
      end
   end

   // Bit counter and input shifter
   // Counting stops in the done phase; a 33rd clock changes nothing
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_reg  <= 6'd0;
         shin_reg <= 32'h0000_0000;
      end else if (phase_reg == PGMS_IDLE) begin
         cnt_reg  <= 6'd0;
      end else if (rise && phase_reg != PGMS_DONE) begin
         cnt_reg  <= cnt_reg + 6'd1;
         shin_reg <= {shin_reg[30:0], sdi_s};
      end
   end

   // Direction latched from the first bit
   // Frame bit 0: 1 reads, 0 writes
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rd_reg <= 1'b0;
      end else if (phase_reg == PGMS_IDLE) begin
         rd_reg <= 1'b0;
      end else if (rise && cnt_reg == 6'd0) begin
         rd_reg <= sdi_s;
      end
   end

   // Read data for the address just received
   // Status values are taken live at the last address bit, so a read
   // returns the state at that instant, not at the end of the frame
   always_comb begin
      unique case ({shin_reg[5:0], sdi_s})
         `PGMS_ADDR_PIN_CFG: begin
            rdata = {14'h0000, pin_cfg_reg};
         end
         `PGMS_ADDR_TUNE: begin
            rdata = {15'h0000, cal_busy_i, tune_reg};
         end
         `PGMS_ADDR_APPROX: begin
            rdata = {4'h0, approx_reg};
         end
         `PGMS_ADDR_LOCK: begin
            rdata = {22'h000000, lock_i, general_level};
         end
         `PGMS_ADDR_SELFTEST: begin
            rdata = {7'h00, `PGMS_RST_SELFTEST};
         end
         default: begin
            rdata = 24'h000000;   // Unmapped reads as zero
         end
      endcase
   end

   // Output shifter: load at last address bit, shift on falling edges
   // The first falling edge after the load keeps bit 23 on the pin
   // until the host has sampled it on the ninth rising edge
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         shout_reg <= 24'h000000;
      end else if (phase_reg == PGMS_IDLE) begin
         shout_reg <= 24'h000000;
      end else if (rise && cnt_reg == `PGMS_HDR_BITS - 6'd1) begin
         shout_reg <= rdata;
      end else if (fall && phase_reg == PGMS_DATA && cnt_reg > `PGMS_HDR_BITS) begin
         shout_reg <= {shout_reg[22:0], 1'b0};
      end
   end

   // Read state lasts until enable is seen low, so a slow host
   // still finds the final bit driven
   assign read_active = rd_reg && (phase_reg == PGMS_DATA || phase_reg == PGMS_DONE);

   // Writable pin config; writes to status addresses fall through
   // At the last rising edge the direction bit sits in bit 30 and the
   // address in bits 29:23; the final data bit is still on the pin
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_cfg_reg <= `PGMS_RST_PIN_CFG;
      end else if (rise && phase_reg == PGMS_DATA && !rd_reg
                   && cnt_reg == `PGMS_FRAME_BITS - 6'd1
                   && shin_reg[29:23] == `PGMS_ADDR_PIN_CFG) begin
         pin_cfg_reg <= {shin_reg[8:0], sdi_s};
      end
   end

   // Tune register follows only calibration results
   // A manual switch change never reaches this register, so software
   // must not read it back as the live switch position
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tune_reg <= `PGMS_RST_TUNE;
      end else if (cal_done_i) begin
         tune_reg <= cal_switch_i;
      end
   end

   // Approximation error captured when the search reports it
   // Sign sits just above the magnitude in the read word
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         approx_reg <= `PGMS_RST_APPROX;
      end else if (approx_valid_i) begin
         approx_reg <= {approx_sign_i, approx_mag_i};
      end
   end

   // Selector for the shared pin
   // Codes with nothing behind them route a constant low
   pgms_route u_route (
      .sel_i       (pin_cfg_reg[`PGMS_SEL_MSB:0]),
      .test_bit_i  (pin_cfg_reg[`PGMS_TEST_BIT]),
      .src_i       (route_src_i),
      .route_o     (routed),
      .pull_up_o   (pull_up),
      .pull_down_o (pull_down)
   );

   // Routed level reaches the pin only when enabled elsewhere
   // Also the general output bit of the lock status register
   assign general_level = pin_enable_i & routed;

   // Pin data: serial data during reads unless automux is off
   // One cycle of latency keeps the pin free of decode glitches;
   // serial data wins only while reading with automux allowed
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_o <= 1'b0;
      end else if (!pin_cfg_reg[`PGMS_NOMUX_BIT] && read_active) begin
         pin_o <= shout_reg[23];
      end else begin
         pin_o <= general_level;
      end
   end

   // Driver enable: always on, or only during a read cycle
   // Driver off outside reads lets other parts share the line;
   // always on suits hosts that expect the line driven between frames
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_oe_o <= 1'b0;
      end else begin
         pin_oe_o <= pin_cfg_reg[`PGMS_ALWAYS_ON_BIT] | read_active;
      end
   end

   // Drive legs, each disabled by its own bit
   // A leg bit of 1 turns that leg off; both legs default to on
   // so the pin can drive both levels straight after reset
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         high_side_drive_en_o <= 1'b1;
         low_side_drive_en_o  <= 1'b1;
      end else begin
         high_side_drive_en_o <= ~pin_cfg_reg[`PGMS_NO_HIGH_BIT];
         low_side_drive_en_o  <= ~pin_cfg_reg[`PGMS_NO_LOW_BIT];
      end
   end

   // Pull requests and fields for the rest of the device
   // Pulls follow the select code, so at most one of them is on;
   // the select copy is registered like the pin itself
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         slip_pull_up_o         <= 1'b0;
         slip_pull_down_o       <= 1'b0;
         output_signal_select_o <= 5'h01;
         general_output_o       <= 1'b0;
      end else begin
         slip_pull_up_o         <= pull_up;
         slip_pull_down_o       <= pull_down;
         output_signal_select_o <= pin_cfg_reg[`PGMS_SEL_MSB:0];
         general_output_o       <= general_level;
      end
   end
endmodule
`default_nettype wire

// *** pgms_regs_sva.sv ***
// Checker for the pin select and status register bank
`default_nettype none
module pgms_regs_sva (
   // Clock, reset, serial enable
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        spi_sen_i,
   // Pin and config outputs
   input wire logic        pin_o,
   input wire logic        pin_oe_o,
   input wire logic        high_side_drive_en_o,
   input wire logic        low_side_drive_en_o,
   input wire logic        slip_pull_up_o,
   input wire logic        slip_pull_down_o,
   input wire logic [4:0]  output_signal_select_o,
   input wire logic        general_output_o,
   // Routed sources and pin enable
   input wire logic        pin_enable_i,
   input wire logic [31:0] route_src_i
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   logic [31:0] src_q; // Sources one edge back
   logic        en_q;  // Pin enable one edge back
   logic        dead;  // Codes that route nothing
   // Output is registered, so compare against last edge's inputs
   always_ff @(posedge clk_sys_i) begin
      src_q <= route_src_i;
      en_q  <= pin_enable_i;
   end
   assign dead = output_signal_select_o inside {5'h05, 5'h06, 5'h07, [5'h1A:5'h1D]};
   // Host idle long enough for every commit and hold to finish
   sequence s_quiet;
      !spi_sen_i [*8];
   endsequence
   // Select unchanged; code 0 depends on a bit not visible here
   sequence s_settled;
      !$past(rst_i) && $stable(output_signal_select_o) && output_signal_select_o != 5'h00;
   endsequence
   AST_RESET_VALUES: assert property ($fell(rst_i) |-> output_signal_select_o == 5'h01
      && high_side_drive_en_o && low_side_drive_en_o && !pin_oe_o) else $error("bad values after reset");
   AST_PULL_UP: assert property ($stable(output_signal_select_o) |->
      slip_pull_up_o == (output_signal_select_o == 5'h05)) else $error("pull up mismatch");
   AST_PULL_DOWN: assert property ($stable(output_signal_select_o) |->
      slip_pull_down_o == (output_signal_select_o == 5'h06)) else $error("pull down mismatch");
   AST_PULL_EXCL: assert property (!(slip_pull_up_o && slip_pull_down_o))
      else $error("both pulls on");
   AST_ROUTE: assert property (s_settled |->
      general_output_o == (!dead && src_q[output_signal_select_o] && en_q)) else $error("route mismatch");
   AST_GATE: assert property (!$past(pin_enable_i) |-> !general_output_o)
      else $error("output not gated");
   AST_QUIET_STABLE: assert property (s_quiet |=> $stable({output_signal_select_o, pin_oe_o,
      high_side_drive_en_o, low_side_drive_en_o})) else $error("config moved without a frame");
   AST_PIN_IDLE: assert property (s_quiet |-> pin_o == general_output_o)
      else $error("idle pin not routed level");
endmodule
bind pgms_regs pgms_regs_sva u_sva (.*);
`default_nettype wire

// *** pgms_host.sv ***
// Serial host model that frames register reads and writes
`default_nettype none
module pgms_host (
   // Pacing clock
   input  wire logic clk_sys_i,
   // Serial pins toward the device
   output logic      sclk_o,
   output logic      sen_o,
   output logic      sdi_o,
   // Shared pin back from the device
   input  wire logic serial_data_out_i,
   input  wire logic oe_i
);
   initial begin
      sclk_o = 1'b0;
      sen_o  = 1'b0;
      sdi_o  = 1'b0;
   end
   // Six clocks a phase keeps clear of the three-flop input delay
   task automatic frame(input logic rd, input logic [6:0] a, input logic [23:0] d,
                        input int nbits, output logic [23:0] q);
      logic [31:0] w;
      w = {rd, a, d};
      q = '0;
      @(negedge clk_sys_i) sen_o = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         sdi_o = w[31-i];
         repeat (6) @(negedge clk_sys_i);
         // An undriven pin reads unknown so a missing enable is caught
         if (i >= 8) q = {q[22:0], oe_i ? serial_data_out_i : 1'bx};
         sclk_o = 1'b1;
         repeat (6) @(negedge clk_sys_i);
         sclk_o = 1'b0;
      end
      // Released data line shows the inverse, not a stale bit
      sdi_o = ~sdi_o;
      sen_o = 1'b0;
      repeat (8) @(negedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

// *** tb_pgms_regs.sv ***
// Testbench for the pin select and status register bank
`include "pgms_params.svh"
`default_nettype none
module tb_pgms_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        sclk, sen, sdi, pin, oe, hi, lo, pu, pdn, go;
   logic        pin_en = 1'b0, busy = 1'b0, done = 1'b0, aval = 1'b0, sign = 1'b0, lock = 1'b0;
   logic [31:0] src = '0;
   logic [7:0]  sw = '0;
   logic [18:0] mag = '0;
   logic [4:0]  sel;
   logic [23:0] q;
   int          mismatches = 0, n_checks = 0, cyc = 0;
   pgms_host host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .sen_o(sen), .sdi_o(sdi),
      .serial_data_out_i(pin), .oe_i(oe));
   pgms_regs dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_sen_i(sen), .spi_sdi_i(sdi),
      .pin_o(pin), .pin_oe_o(oe), .high_side_drive_en_o(hi), .low_side_drive_en_o(lo),
      .slip_pull_up_o(pu), .slip_pull_down_o(pdn), .pin_enable_i(pin_en), .route_src_i(src),
      .cal_busy_i(busy), .cal_done_i(done), .cal_switch_i(sw), .approx_valid_i(aval),
      .approx_mag_i(mag), .approx_sign_i(sign), .lock_i(lock), .output_signal_select_o(sel),
      .general_output_o(go));
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   // Cut a hang short well past the expected run length
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [23:0] d);
      host.frame(1'b0, a, d, 32, q);
   endtask
   task automatic rd(input logic [6:0] a);
      host.frame(1'b1, a, 24'h0, 32, q);
   endtask
   // Reset values of every register, idle pin, unmapped place
   task automatic t_reset();
      chk("select", 24'(sel), 24'h1);
      chk("legs", {22'h0, hi, lo}, 24'h3);
      chk("oe idle", 24'(oe), 24'h0);
      rd(`PGMS_ADDR_PIN_CFG);
      chk("cfg", q, 24'h000001);
      rd(`PGMS_ADDR_TUNE);
      chk("tune", q, 24'h000020);
      rd(`PGMS_ADDR_APPROX);
      chk("approx", q, 24'h07FFFF);
      rd(`PGMS_ADDR_LOCK);
      chk("lock", q, 24'h000000);
      rd(`PGMS_ADDR_SELFTEST);
      chk("selftest", q, 24'h001259);
      wr(7'h20, 24'hFFFFFF);
      rd(7'h20);
      chk("unmapped", q, 24'h0);
      $display("t_reset done");
   endtask
   // Every select code with sources low and high, test bit set
   task automatic t_route();
      logic e;
      pin_en = 1'b1;
      for (int k = 0; k < 32; k++) begin
         wr(`PGMS_ADDR_PIN_CFG, 24'(k) | 24'h20);
         chk("select", 24'(sel), 24'(k));
         for (int v = 0; v < 2; v++) begin
            src = v ? 32'hFFFFFFFF : 32'h0;
            repeat (3) @(negedge clk_sys_i);
            e = (k == 0) ? 1'b1 : (k inside {5, 6, 7, [26:29]}) ? 1'b0 : v[0];
            chk("route", 24'(go), 24'(e));
            chk("pin", 24'(pin), 24'(e));
         end
         chk("pulls", {22'h0, pu, pdn}, {22'h0, k == 5, k == 6});
      end
      pin_en = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk("gated", 24'(go), 24'h0);
      $display("t_route done");
   endtask
   // Driver always on, legs off, then automux prevented during a read
   task automatic t_pin();
      wr(`PGMS_ADDR_PIN_CFG, 24'h000380);
      chk("oe on", 24'(oe), 24'h1);
      chk("legs off", {22'h0, hi, lo}, 24'h0);
      src = '0;
      pin_en = 1'b1;
      wr(`PGMS_ADDR_PIN_CFG, 24'h000041);
      rd(`PGMS_ADDR_PIN_CFG);
      chk("no automux", q, 24'h0);
      // Automux left on so the read shows serial data, not the pin level
      wr(`PGMS_ADDR_PIN_CFG, 24'hFFFFBF);
      rd(`PGMS_ADDR_PIN_CFG);
      chk("cfg width", q, 24'h0003BF);
      $display("t_pin done");
   endtask
   // Status inputs, stale tune value, writes to read-only places
   task automatic t_status();
      busy = 1'b1;
      sw = 8'h3C;
      rd(`PGMS_ADDR_TUNE);
      chk("busy", 24'(q[8]), 24'h1);
      // Switch setting is not judged while busy is reported
      busy = 1'b0;
      sw = 8'hFF;
      done = 1'b1;
      @(negedge clk_sys_i) done = 1'b0;
      rd(`PGMS_ADDR_TUNE);
      chk("tune", q, 24'h0000FF);
      sw = 8'h00;
      rd(`PGMS_ADDR_TUNE);
      chk("tune kept", q, 24'h0000FF);
      mag = 19'h5A5A5;
      sign = 1'b1;
      aval = 1'b1;
      @(negedge clk_sys_i) aval = 1'b0;
      src = '1;
      lock = 1'b1;
      wr(`PGMS_ADDR_PIN_CFG, 24'h000001);
      for (int a = 16; a < 20; a++) wr(7'(a), 24'hFFFFFF);
      rd(`PGMS_ADDR_APPROX);
      chk("approx", q, 24'h0DA5A5);
      rd(`PGMS_ADDR_LOCK);
      chk("lock", q, 24'h000003);
      rd(`PGMS_ADDR_TUNE);
      chk("tune ro", q, 24'h0000FF);
      rd(`PGMS_ADDR_SELFTEST);
      chk("selftest ro", q, 24'h001259);
      chk("oe off", 24'(oe), 24'h0);
      $display("t_status done");
   endtask
   initial begin
      repeat (4) @(negedge clk_sys_i);
      rst_i = 1'b0;
      t_reset();
      t_route();
      t_pin();
      t_status();
      test_done();
   end
endmodule
`default_nettype wire
